// ---- mdr_pkg.sv ----
// Package for the multidrop serial receive/direction block.
// Assumes a single 200 MHz clock and a 16x oversampled bit clock.
package mdr_pkg;
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned BAUD_DIV_RST   = 1736;
    localparam int unsigned DATA_BITS      = 8;
    localparam int unsigned FRAME_BITS     = 9;
    localparam int unsigned FIFO_DEPTH     = 4;
    localparam int unsigned FIFO_WIDTH     = 9;
    localparam int unsigned PIN_SYNC_STAGES = 3;
    localparam logic [7:0]  NODE_ADDR_RST  = 8'h00;
    localparam logic        RX_EN_RST      = 1'b0;
    localparam int unsigned OVERSAMPLE     = 16;
    localparam int unsigned HALF_SAMPLE    = 8;
    localparam int unsigned TURN_OFF_CYC   = 1;

    typedef enum logic [1:0] {
        MDR_RX_IDLE,
        MDR_RX_START,
        MDR_RX_DATA,
        MDR_RX_STOP
    } mdr_rx_state_t;

    typedef enum logic [1:0] {
        MDR_TX_IDLE,
        MDR_TX_START,
        MDR_TX_DATA,
        MDR_TX_STOP
    } mdr_tx_state_t;
endpackage

// ---- mdr_fifo_if.sv ----
// Interface carrying the receive stream into the word buffer.
// Assumes both modports sit on the same clock.
`timescale 1ns/1ps
interface mdr_fifo_if #(parameter int WIDTH = 9);
    logic [WIDTH-1:0] wr_data;
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] rd_data;
    logic             rd_valid;
    logic             rd_ready;
    modport src (output wr_data, output wr_valid, input wr_ready,
                 input rd_data, input rd_valid, output rd_ready);
    modport buf_side (input wr_data, input wr_valid, output wr_ready,
                      output rd_data, output rd_valid, input rd_ready);
endinterface

// ---- mdr_fifo.sv ----
// Receive word buffer, registered read data, valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module mdr_fifo
    import mdr_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic  clock,
    input  wire logic  rst,
    input  wire logic  clk_en,
    mdr_fifo_if.buf_side f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
    logic [WIDTH-1:0] out_q, out_d;
    logic             ov_q, ov_d;
    logic             full, empty, push, pop;

    assign full       = (wp_q[AW] != rp_q[AW]) &&
                        (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty      = (wp_q == rp_q);
    assign f.wr_ready = !full;
    assign f.rd_valid = ov_q;
    assign f.rd_data  = out_q;

    always_comb begin
        push = f.wr_valid && !full;
        pop  = !empty && (!ov_q || f.rd_ready);
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        out_d = pop ? mem_q[rp_q[AW-1:0]] : out_q;
        ov_d  = pop ? 1'b1 : (f.rd_ready ? 1'b0 : ov_q);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            out_q <= '0;
            ov_q  <= 1'b0;
        end else if (clk_en) begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            out_q <= out_d;
            ov_q  <= ov_d;
            if (push) begin
                mem_q[wp_q[AW-1:0]] <= f.wr_data;
            end
        end
    end
endmodule

// ---- mdr_port.sv ----
// Multidrop serial port: 9-bit receiver with address filtering,
// 9-bit transmitter with automatic driver direction control.
// Assumes pins are asynchronous; control bits come from plain ports.
//
// Overview of operation
// - Software picks manual or automatic rejection of foreign data.
// - Normal mode: ninth bit set raises parity error flag and event.
// - Normal mode, receiver off: data bytes are dropped, not buffered.
// - Normal mode, receiver off: address bytes buffered, data ready raised.
// - Normal mode, receiver on: every byte is buffered.
// - Normal mode, receiver on: address byte raises parity error event.
// - Auto mode compares address bytes with an 8-bit node address.
// - Auto mode, receiver off: data and foreign addresses are discarded.
// - Matching address while off: buffered with ninth bit, receiver enabled.
// - Auto mode, receiver on: bytes buffered until foreign address arrives.
// - Foreign address while on: receiver disabled, byte not buffered.
// - Auto direction: transmitter drives chosen RTS or DTR itself.
// - Driver enable released promptly after final stop bit.
`timescale 1ns/1ps
module mdr_port
    import mdr_pkg::*;
#(
    parameter int        FIFO_W   = FIFO_WIDTH,
    parameter int        FIFO_D   = FIFO_DEPTH,
    parameter bit [15:0] BAUD_DIV = 16'(BAUD_DIV_RST)
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // Mode and configuration
    input  wire logic       normal_multidrop_mode,
    input  wire logic       auto_address_detect_mode,
    input  wire logic [7:0] node_address_match_value,
    input  wire logic       rx_enable_wr,
    input  wire logic       rx_enable_wdata,
    input  wire logic       auto_dir_enable,
    input  wire logic       dir_select_dtr,
    input  wire logic       dir_invert,
    // Receive side
    input  wire logic       rxd_pin,
    output logic [8:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic            rx_enable,
    output logic            parity_error_pulse,
    output logic            rx_data_ready_pulse,
    output logic            rx_overrun_pulse,
    // Transmit side
    input  wire logic [8:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic       tx_more_queued,
    output logic            txd_pin,
    output logic            tx_busy,
    output logic            rts_pin,
    output logic            dtr_pin
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser, three stages

    logic [PIN_SYNC_STAGES-1:0] rx_sync_q, rx_sync_d;
    logic                       rx_line_q, rx_line_d;

    always_comb begin
        rx_sync_d = {rx_sync_q[PIN_SYNC_STAGES-2:0], rxd_pin};
        // Only move once second and third stages agree
        rx_line_d = (rx_sync_q[1] == rx_sync_q[2]) ? rx_sync_q[2] : rx_line_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_sync_q <= '1;
            rx_line_q <= 1'b1;
        end else if (clk_en) begin
            rx_sync_q <= rx_sync_d;
            rx_line_q <= rx_line_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oversample tick shared by both directions

    logic [15:0] tick_cnt_q, tick_cnt_d;
    logic        tick;

    always_comb begin
        tick       = (tick_cnt_q == 16'h0000);
        tick_cnt_d = tick ? (BAUD_DIV / 16'(OVERSAMPLE)) - 16'h0001
                          : tick_cnt_q - 16'h0001;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tick_cnt_q <= '0;
        end else if (clk_en) begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receiver framing: start, 8 data, ninth bit, stop

    mdr_rx_state_t rx_st_q, rx_st_d;
    logic [3:0]    rx_os_q, rx_os_d;
    logic [3:0]    rx_bit_q, rx_bit_d;
    logic [8:0]    rx_sh_q, rx_sh_d;
    logic          rx_done;

    always_comb begin
        rx_st_d  = rx_st_q;
        rx_os_d  = rx_os_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d  = rx_sh_q;
        rx_done  = 1'b0;
        case (rx_st_q)
            MDR_RX_IDLE: begin
                if (!rx_line_q) begin
                    rx_st_d = MDR_RX_START;
                    rx_os_d = '0;
                end
            end
            MDR_RX_START: begin
                if (tick) begin
                    rx_os_d = rx_os_q + 4'h1;
                    if (rx_os_q == 4'(HALF_SAMPLE - 1)) begin
                        // Glitch on the start bit returns to idle
                        rx_st_d  = rx_line_q ? MDR_RX_IDLE : MDR_RX_DATA;
                        rx_os_d  = '0;
                        rx_bit_d = '0;
                    end
                end
            end
            MDR_RX_DATA: begin
                if (tick) begin
                    rx_os_d = rx_os_q + 4'h1;
                    if (rx_os_q == 4'(OVERSAMPLE - 1)) begin
                        rx_sh_d  = {rx_line_q, rx_sh_q[8:1]};
                        rx_bit_d = rx_bit_q + 4'h1;
                        if (rx_bit_q == 4'(FRAME_BITS - 1)) begin
                            rx_st_d = MDR_RX_STOP;
                        end
                    end
                end
            end
            MDR_RX_STOP: begin
                if (tick) begin
                    rx_os_d = rx_os_q + 4'h1;
                    if (rx_os_q == 4'(OVERSAMPLE - 1)) begin
                        rx_st_d = MDR_RX_IDLE;
                        rx_done = 1'b1;
                    end
                end
            end
            default: rx_st_d = MDR_RX_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_st_q  <= MDR_RX_IDLE;
            rx_os_q  <= '0;
            rx_bit_q <= '0;
            rx_sh_q  <= '0;
        end else if (clk_en) begin
            rx_st_q  <= rx_st_d;
            rx_os_q  <= rx_os_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q  <= rx_sh_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address filter and receiver enable

    mdr_fifo_if #(.WIDTH(FIFO_W)) rxf ();

    logic rx_en_q, rx_en_d;
    logic is_addr, addr_match, store;
    logic pe_q, pe_d, rdy_q, rdy_d, ovr_q, ovr_d;

    always_comb begin
        // Ninth bit marks an address character
        is_addr    = rx_sh_q[8];
        addr_match = (rx_sh_q[7:0] == node_address_match_value);
        rx_en_d    = rx_enable_wr ? rx_enable_wdata : rx_en_q;
        store      = 1'b0;
        pe_d       = 1'b0;
        if (rx_done) begin
            if (auto_address_detect_mode) begin
                if (!rx_en_q) begin
                    if (is_addr && addr_match) begin
                        store   = 1'b1;
                        rx_en_d = 1'b1;
                    end
                    // Else discarded
                end else if (is_addr && !addr_match) begin
                    rx_en_d = 1'b0;
                end else begin
                    store = 1'b1;
                end
            end else if (normal_multidrop_mode) begin
                pe_d  = is_addr;
                // Off: address only on: all
                store = rx_en_q || is_addr;
            end else begin
                // Plain port: everything buffered, enable honoured
                store = rx_en_q;
            end
        end
        rdy_d = store && rxf.wr_ready;
        ovr_d = store && !rxf.wr_ready;
    end

    assign rxf.wr_data  = rx_sh_q;
    assign rxf.wr_valid = store;
    assign rxf.rd_ready = rx_ready;

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_en_q <= RX_EN_RST;
            pe_q    <= 1'b0;
            rdy_q   <= 1'b0;
            ovr_q   <= 1'b0;
        end else if (clk_en) begin
            rx_en_q <= rx_en_d;
            pe_q    <= pe_d;
            rdy_q   <= rdy_d;
            ovr_q   <= ovr_d;
        end
    end

    mdr_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_rx_fifo (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .f      (rxf)
    );

    assign rx_data             = rxf.rd_data;
    assign rx_valid            = rxf.rd_valid;
    assign rx_enable           = rx_en_q;
    assign parity_error_pulse  = pe_q;
    assign rx_data_ready_pulse = rdy_q;
    assign rx_overrun_pulse    = ovr_q;

    ////////////////////////////////////////////////////////////////////
    // Transmitter with direction control

    mdr_tx_state_t tx_st_q, tx_st_d;
    logic [3:0]    tx_os_q, tx_os_d;
    logic [3:0]    tx_bit_q, tx_bit_d;
    logic [8:0]    tx_sh_q, tx_sh_d;
    logic          txd_q, txd_d;
    logic          dir_q, dir_d;
    logic          tx_take;

    always_comb begin
        tx_st_d  = tx_st_q;
        tx_os_d  = tx_os_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d  = tx_sh_q;
        txd_d    = txd_q;
        tx_take  = 1'b0;
        case (tx_st_q)
            MDR_TX_IDLE: begin
                txd_d = 1'b1;
                // Wait one idle cycle with direction up before start bit
                if (tx_valid && dir_q && auto_dir_enable) begin
                    tx_take = 1'b1;
                    tx_sh_d = tx_data;
                    tx_st_d = MDR_TX_START;
                    tx_os_d = '0;
                    txd_d   = 1'b0;
                end
            end
            MDR_TX_START: begin
                if (tick) begin
                    tx_os_d = tx_os_q + 4'h1;
                    if (tx_os_q == 4'(OVERSAMPLE - 1)) begin
                        tx_st_d  = MDR_TX_DATA;
                        tx_bit_d = '0;
                        txd_d    = tx_sh_q[0];
                    end
                end
            end
            MDR_TX_DATA: begin
                if (tick) begin
                    tx_os_d = tx_os_q + 4'h1;
                    if (tx_os_q == 4'(OVERSAMPLE - 1)) begin
                        tx_sh_d  = {1'b0, tx_sh_q[8:1]};
                        tx_bit_d = tx_bit_q + 4'h1;
                        if (tx_bit_q == 4'(FRAME_BITS - 1)) begin
                            tx_st_d = MDR_TX_STOP;
                            txd_d   = 1'b1;
                        end else begin
                            txd_d = tx_sh_q[1];
                        end
                    end
                end
            end
            MDR_TX_STOP: begin
                if (tick) begin
                    tx_os_d = tx_os_q + 4'h1;
                    if (tx_os_q == 4'(OVERSAMPLE - 1)) begin
                        tx_st_d = MDR_TX_IDLE;
                    end
                end
            end
            default: tx_st_d = MDR_TX_IDLE;
        endcase
        // Drop right after stop bit unless more is queued
        dir_d = auto_dir_enable &&
                (tx_valid || tx_more_queued ||
                 (tx_st_d != MDR_TX_IDLE));
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_st_q  <= MDR_TX_IDLE;
            tx_os_q  <= '0;
            tx_bit_q <= '0;
            tx_sh_q  <= '0;
            txd_q    <= 1'b1;
            dir_q    <= 1'b0;
        end else if (clk_en) begin
            tx_st_q  <= tx_st_d;
            tx_os_q  <= tx_os_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q  <= tx_sh_d;
            txd_q    <= txd_d;
            dir_q    <= dir_d;
        end
    end

    assign tx_ready = tx_take;
    assign txd_pin  = txd_q;
    assign tx_busy  = (tx_st_q != MDR_TX_IDLE);
    // Unselected pin idles inactive
    assign rts_pin  = (!dir_select_dtr && dir_q) ^ dir_invert;
    assign dtr_pin  = (dir_select_dtr && dir_q) ^ dir_invert;

endmodule

// ---- mdr_port_assertions.sv ----
// Concurrent checks on the multidrop port, seen from its ports only.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module mdr_port_checker (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       normal_multidrop_mode,
    input wire logic       auto_address_detect_mode,
    input wire logic       rx_enable_wr,
    input wire logic       rx_enable_wdata,
    input wire logic       auto_dir_enable,
    input wire logic       dir_select_dtr,
    input wire logic       dir_invert,
    input wire logic [8:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic       rx_enable,
    input wire logic       parity_error_pulse,
    input wire logic       rx_data_ready_pulse,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       tx_more_queued,
    input wire logic       txd_pin,
    input wire logic       tx_busy,
    input wire logic       rts_pin,
    input wire logic       dtr_pin
);
    logic dir_act;

    // Direction as the transceiver sees it, polarity removed
    assign dir_act = auto_dir_enable &&
        ((dir_select_dtr ? dtr_pin : rts_pin) != dir_invert);

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    sequence s_take;
        tx_ready && dir_act && !tx_busy;
    endsequence
    sequence s_start;
        tx_busy && !txd_pin;
    endsequence

    tx_start_a: assert property (s_take |=> s_start)
        else $error("start bit not launched after word taken");
    dir_busy_a: assert property (tx_busy |-> dir_act)
        else $error("direction dropped during a frame");
    dir_hold_a: assert property (auto_dir_enable && tx_more_queued && dir_act
        |=> dir_act)
        else $error("direction dropped with words queued");
    dir_release_a: assert property ($fell(tx_busy) && !tx_valid &&
        !tx_more_queued |-> ##[1:3] !dir_act)
        else $error("direction not released after stop bit");
    no_dir_tx_a: assert property (!auto_dir_enable |-> !tx_ready)
        else $error("word taken without direction control");
    parity_flag_a: assert property (parity_error_pulse |->
        normal_multidrop_mode && !auto_address_detect_mode &&
        rx_data_ready_pulse)
        else $error("parity flag outside normal mode address push");
    sw_enable_a: assert property (!auto_address_detect_mode &&
        !rx_enable_wr |=> $stable(rx_enable))
        else $error("receiver enable changed without a write");
    sw_write_a: assert property (rx_enable_wr &&
        !auto_address_detect_mode |=> rx_enable == $past(rx_enable_wdata))
        else $error("receiver enable write lost");
    auto_on_a: assert property (auto_address_detect_mode &&
        $rose(rx_enable) && !$past(rx_enable_wr) |-> rx_data_ready_pulse)
        else $error("auto enable without pushing the address");
    auto_off_a: assert property (auto_address_detect_mode &&
        $fell(rx_enable) && !$past(rx_enable_wr) |-> !rx_data_ready_pulse)
        else $error("foreign address pushed");
    rx_hold_a: assert property (rx_valid && !rx_ready |=>
        rx_valid && $stable(rx_data))
        else $error("receive word changed before taken");
endmodule

bind mdr_port mdr_port_checker chk (
    .clock, .rst, .normal_multidrop_mode, .auto_address_detect_mode,
    .rx_enable_wr, .rx_enable_wdata, .auto_dir_enable, .dir_select_dtr,
    .dir_invert, .rx_data, .rx_valid, .rx_ready, .rx_enable,
    .parity_error_pulse, .rx_data_ready_pulse, .tx_valid, .tx_ready,
    .tx_more_queued, .txd_pin, .tx_busy, .rts_pin, .dtr_pin
);

// ---- mdr_master_node.sv ----
// Model of the bus master node and of the transceiver receive path.
// Assumes one clock; BIT is the bit time in clock cycles.
`timescale 1ns/1ps
module mdr_master_node #(
    parameter int BIT = 32
) (
    input  wire logic clock,
    input  wire logic txd_pin,
    output logic      rxd_pin,
    output logic [8:0] tx_word,
    output int        tx_cnt
);
    initial begin
        rxd_pin = 1'b1;
        tx_word = 9'h000;
        tx_cnt = 0;
    end

    // Caller sets the ninth bit: one for address, zero for data
    task automatic send(input logic [8:0] w);
        logic [10:0] f;
        f = {1'b1, w, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clock);
            rxd_pin <= f[i];
            repeat (BIT - 1) @(posedge clock);
        end
    endtask

    ////////////////////////////////////////
    // Mid-bit sampling; a bad stop bit leaves the count unchanged
    initial forever begin
        @(negedge txd_pin);
        repeat (BIT / 2) @(posedge clock);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clock);
            tx_word[i] <= txd_pin;
        end
        repeat (BIT) @(posedge clock);
        if (txd_pin === 1'b1) tx_cnt <= tx_cnt + 1;
    end
endmodule

// ---- uart_rs485_multidrop_rx_bench.sv ----
// Self-checking bench: receive filtering, buffer fill, direction control.
// Assumes the master node model drives rxd and decodes txd.
`timescale 1ns/1ps
module uart_rs485_multidrop_rx_bench;
    logic       clock = 1'b0, rst = 1'b1, nm = 1'b0, am = 1'b0, wr = 1'b0;
    logic       wd = 1'b0, ade = 1'b0, dsel = 1'b0, dinv = 1'b0;
    logic       exp_en = 1'b0, rx_ready = 1'b1, tx_valid = 1'b0, more = 1'b0;
    logic       txd, rxd, rx_valid, rx_en, pe, rdy, ov, tx_ready, tx_busy;
    logic       rts, dtr;
    logic [7:0] node = 8'h00;
    logic [8:0] tx_data = 9'h000, rx_data, tx_word, got_q[$];
    int         num_errors = 0, checks_done = 0, seed = 34085, cyc = 0;
    int         n_pe = 0, n_rdy = 0, n_ov = 0, b_pe, b_rdy, b_ov, n0, k;
    int         tx_cnt;

    mdr_port #(.BAUD_DIV(16'h0020)) uut (
        .clock(clock), .rst(rst), .clk_en(1'b1),
        .normal_multidrop_mode(nm), .auto_address_detect_mode(am),
        .node_address_match_value(node), .rx_enable_wr(wr),
        .rx_enable_wdata(wd), .auto_dir_enable(ade),
        .dir_select_dtr(dsel), .dir_invert(dinv), .rxd_pin(rxd),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_enable(rx_en), .parity_error_pulse(pe),
        .rx_data_ready_pulse(rdy), .rx_overrun_pulse(ov),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_more_queued(more), .txd_pin(txd), .tx_busy(tx_busy),
        .rts_pin(rts), .dtr_pin(dtr));
    mdr_master_node #(.BIT(32)) node_model (.clock(clock), .txd_pin(txd),
        .rxd_pin(rxd), .tx_word(tx_word), .tx_cnt(tx_cnt));

    initial begin
        forever #2.5 clock = ~clock;
    end

    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////
    always @(posedge clock) begin
        if (rx_valid && rx_ready) got_q.push_back(rx_data);
        n_pe <= n_pe + int'(pe);
        n_rdy <= n_rdy + int'(rdy);
        n_ov <= n_ov + int'(ov);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    // Returns {stored, enable after, parity flag}
    function automatic logic [2:0] predict(input logic [8:0] w);
        logic m;
        m = w[7:0] == node;
        if (am) return w[8] ? {m, m, 1'b0} : {exp_en, exp_en, 1'b0};
        if (nm) return {exp_en | w[8], exp_en, w[8]};
        return {exp_en, exp_en, 1'b0};
    endfunction

    function automatic logic dact();
        return ade && ((dsel ? dtr : rts) ^ dinv);
    endfunction

    task automatic sw_en(input logic v);
        @(posedge clock);
        wr <= 1'b1;
        wd <= v;
        @(posedge clock);
        wr <= 1'b0;
        exp_en = v;
    endtask

    task automatic rx_frame(input logic [8:0] w);
        logic [2:0] e;
        e = predict(w);
        b_pe = n_pe;
        b_rdy = n_rdy;
        n0 = got_q.size();
        node_model.send(w);
        repeat (12) @(posedge clock);
        exp_en = e[1];
        check(9'(rx_en), 9'(exp_en));
        check(9'(n_rdy - b_rdy), 9'(e[2]));
        check(9'(n_pe - b_pe), 9'(e[0]));
        check(9'(got_q.size() - n0), 9'(e[2]));
        if (e[2]) check(got_q[n0], w);
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // Modes in turn: normal, auto detect, then neither
        for (int m = 0; m < 3; m++) begin
            @(posedge clock);
            nm <= m == 0;
            am <= m == 1;
            node <= 8'($random(seed));
            repeat (2) @(posedge clock);
            rx_frame({1'b1, node});
            rx_frame({1'b1, ~node});
            for (int i = 0; i < 12; i++) begin
                k = $random(seed) & 3;
                if (i == 6) sw_en(!exp_en);
                rx_frame(k == 0 ? {1'b1, node} : {k == 1, 8'($random(seed))});
            end
        end
        // Consumer stalls: output register plus four words, sixth is lost
        nm <= 1'b1;
        am <= 1'b0;
        sw_en(1'b1);
        rx_ready <= 1'b0;
        b_ov = n_ov;
        n0 = got_q.size();
        for (int i = 0; i < 6; i++) node_model.send({1'b0, 8'(8'hF0 + i)});
        repeat (12) @(posedge clock);
        check(9'(n_ov - b_ov), 9'h001);
        rx_ready <= 1'b1;
        repeat (12) @(posedge clock);
        check(9'(got_q.size() - n0), 9'h005);
        for (int i = 0; i < 5; i++) begin
            check(got_q[n0 + i], {1'b0, 8'(8'hF0 + i)});
        end
        // Every pin choice and polarity; last one keeps words queued
        for (int c = 0; c < 4; c++) begin
            @(posedge clock);
            ade <= 1'b1;
            dsel <= c[0];
            dinv <= c[1];
            more <= c == 3;
            tx_data <= 9'($random(seed));
            tx_valid <= 1'b1;
            b_pe = tx_cnt;
            // Sample the combinational handshake mid-cycle, where it is settled
            for (k = 0; k < 20 && tx_ready !== 1'b1; k++) @(negedge clock);
            check(9'({dact(), txd}), 9'h003);
            @(posedge clock);
            tx_valid <= 1'b0;
            for (k = 0; k < 600 && tx_cnt == b_pe; k++) @(posedge clock);
            check(tx_word, tx_data);
            repeat (24) @(posedge clock);
            check(9'(dact()), 9'(c == 3));
            more <= 1'b0;
            repeat (4) @(posedge clock);
            check(9'(dact()), 9'h000);
        end
        // Without direction control nothing may be sent
        ade <= 1'b0;
        tx_valid <= 1'b1;
        repeat (40) @(posedge clock);
        check(9'({tx_busy, txd}), 9'h001);
        tx_valid <= 1'b0;
        stop_test();
    end
endmodule
